// >>> hw/ttcc_pkg.sv
package ttcc_pkg;

  // register byte offsets on the apb window
  localparam logic [7:0] OFF_CTRL        = 8'h00;
  localparam logic [7:0] OFF_INIT_LOW    = 8'h04;
  localparam logic [7:0] OFF_INIT_HIGH   = 8'h08;
  localparam logic [7:0] OFF_TIME_LOW    = 8'h0c;
  localparam logic [7:0] OFF_TIME_HIGH   = 8'h10;
  localparam logic [7:0] OFF_CMP_LOW     = 8'h14;
  localparam logic [7:0] OFF_CMP_HIGH    = 8'h18;
  localparam logic [7:0] OFF_MASK_LOW    = 8'h1c;
  localparam logic [7:0] OFF_MASK_HIGH   = 8'h20;
  localparam logic [7:0] OFF_TICK_PERIOD = 8'h24;
  localparam logic [7:0] OFF_STATUS      = 8'h28;

  // transport_time_control fields
  localparam int unsigned CTRL_COUNT_EN_BIT = 5;
  localparam int unsigned CTRL_TICK_EN_BIT  = 4;
  localparam int unsigned CTRL_CMP_EN_BIT   = 3;
  localparam int unsigned CTRL_INC_SEL_BIT  = 2;
  localparam int unsigned CTRL_FILTER_BIT   = 1;

  // high word layout shared by init, time, compare and mask
  localparam int unsigned HIGH_TOP_BIT = 0;
  localparam int unsigned HIGH_EXT_LSB = 1;
  localparam int unsigned HIGH_EXT_MSB = 9;

  // status fields, write one to clear
  localparam int unsigned STAT_TICK_BIT  = 0;
  localparam int unsigned STAT_MATCH_BIT = 1;

  localparam int unsigned EXT_W  = 9;
  localparam int unsigned BASE_W = 33;
  localparam logic [8:0]  EXT_LAST = 9'h12b;

  localparam logic [31:0] RST_ZERO        = 32'h0000_0000;
  localparam logic [31:0] TICK_PERIOD_RST = 32'h0000_0100;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } ttcc_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ttcc_apb_rsp_t;

  typedef struct packed {
    logic        valid;
    logic        last;
    logic        err;
    logic [31:0] data;
  } ttcc_pkt_t;

  typedef enum logic [3:0] {
    REG_CTRL, REG_INIT_LOW, REG_INIT_HIGH, REG_TIME_LOW, REG_TIME_HIGH, REG_CMP_LOW,
    REG_CMP_HIGH, REG_MASK_LOW, REG_MASK_HIGH, REG_TICK_PERIOD, REG_STATUS, REG_NONE
  } ttcc_reg_t;

  typedef enum logic [1:0] {
    PF_IDLE  = 2'b00,
    PF_BODY  = 2'b01,
    PF_STAMP = 2'b11
  } ttcc_pf_state_t;

  function automatic ttcc_reg_t ttcc_decode(input logic [7:0] addr);
    unique case (addr)
      OFF_CTRL:        return REG_CTRL;
      OFF_INIT_LOW:    return REG_INIT_LOW;
      OFF_INIT_HIGH:   return REG_INIT_HIGH;
      OFF_TIME_LOW:    return REG_TIME_LOW;
      OFF_TIME_HIGH:   return REG_TIME_HIGH;
      OFF_CMP_LOW:     return REG_CMP_LOW;
      OFF_CMP_HIGH:    return REG_CMP_HIGH;
      OFF_MASK_LOW:    return REG_MASK_LOW;
      OFF_MASK_HIGH:   return REG_MASK_HIGH;
      OFF_TICK_PERIOD: return REG_TICK_PERIOD;
      OFF_STATUS:      return REG_STATUS;
      default:         return REG_NONE;
    endcase
  endfunction

endpackage

// >>> hw/ttcc_sync_edge.sv
`timescale 1ns/1ps
module ttcc_sync_edge
  import ttcc_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_async,
  output logic      o_rise
);
  logic meta;
  logic stable;
  logic prev;

  // only stable and prev feed the edge detector
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta   <= 1'b0;
      stable <= 1'b0;
      prev   <= 1'b0;
    end else begin
      meta   <= i_async;
      stable <= meta;
      prev   <= stable;
    end
  end

  assign o_rise = stable & ~prev;
endmodule // ttcc_sync_edge

// >>> hw/ttcc_pkt_filter.sv
`timescale 1ns/1ps
module ttcc_pkt_filter
  import ttcc_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire ttcc_pkt_t   i_pkt,
  input  wire logic        i_filter,
  input  wire logic [30:0] i_stamp_time,
  output logic             o_pkt_ready,
  output logic             o_fifo_wr,
  output logic [31:0]      o_fifo_data
);
  ttcc_pf_state_t state;
  logic           drop;
  logic           marker;
  logic           take;
  logic           first_drop;

  assign o_pkt_ready = (state != PF_STAMP);
  assign take        = i_pkt.valid & o_pkt_ready;
  // filter choice is latched per packet so a mid-packet change cannot split it
  assign first_drop  = i_filter & i_pkt.err;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state  <= PF_IDLE;
      drop   <= 1'b0;
      marker <= 1'b0;
    end else begin
      unique case (state)
        PF_IDLE: if (take) begin
          drop   <= first_drop;
          marker <= i_pkt.err;
          if (i_pkt.last) begin
            state <= first_drop ? PF_IDLE : PF_STAMP;
          end else begin
            state <= PF_BODY;
          end
        end
        PF_BODY: if (take) begin
          marker <= marker | i_pkt.err;
          if (i_pkt.last) begin
            state <= drop ? PF_IDLE : PF_STAMP;
          end
        end
        PF_STAMP: state <= PF_IDLE;
        default:  state <= PF_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_fifo_wr   <= 1'b0;
      o_fifo_data <= RST_ZERO;
    end else if (state == PF_STAMP) begin
      o_fifo_wr   <= 1'b1;
      o_fifo_data <= {marker, i_stamp_time};
    end else begin
      o_fifo_wr   <= take & ~((state == PF_IDLE) ? first_drop : drop);
      o_fifo_data <= i_pkt.data;
    end
  end

  a_drop_silent: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state == PF_BODY && drop && take) |=> !o_fifo_wr)
    else $error("dropped packet word reached the fifo");
  a_stamp_marker: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state == PF_STAMP) |=> (o_fifo_wr && o_fifo_data[31] == $past(marker)))
    else $error("packet stamp missing or marker wrong");
endmodule // ttcc_pkt_filter

// >>> hw/ttcc_top.sv
// How it works
// - error filter, compare enable and tick enable are writable at any time.
// - increment select write is ignored while counting is enabled.
// - count enable low gates the time input; nothing advances.
// - count enable high advances counters and tick counter on time input edges.
// - tick enable high sets tick flag when tick count reached, except on a step that meets an init load; low never.
// - compare enable high lets a compare match set the match flag.
// - select 0: reference part steps when extension wraps 299 to 0.
// - select 1: reference part steps on every time input edge.
// - filter off: errored packets stored, stamp carries the error marker.
// - filter on: packets errored on their first word discarded, nothing written to the fifo.
// - control bits 31-6 read zero and ignore writes.
// - writing either init register loads the whole counter from both.
// - low init register is 32-bit read/write, resets to zero.
// - high init: extension in bits 9-1, reference top bit 0, rest zero.
// - match when compare value equals unmasked counter bits.
// - extension advances at the time input rate.
`timescale 1ns/1ps
module ttcc_top
  import ttcc_pkg::*;
#(
  parameter logic [31:0] TICK_PERIOD_DEFAULT = TICK_PERIOD_RST
)(
  input  wire logic          i_clk,
  input  wire logic          i_rst_n,
  input  wire ttcc_apb_req_t i_apb,
  output ttcc_apb_rsp_t      o_apb,
  input  wire logic          i_system_time_input_clock,
  input  wire ttcc_pkt_t     i_pkt,
  output logic               o_pkt_ready,
  output logic               o_fifo_wr,
  output logic [31:0]        o_fifo_data,
  output logic               o_tick_event,
  output logic               o_time_match_event
);
  ttcc_reg_t     sel;
  logic          setup;
  logic          access;
  logic          wr;
  logic [31:0]   wdata;
  logic [31:0]   read_val;
  logic [31:0]   prdata;
  logic          pslverr;

  logic          count_en;
  logic          tick_en;
  logic          cmp_en;
  logic          inc_sel;
  logic          filter;
  logic [31:0]   init_low;
  logic [9:0]    init_high;
  logic [31:0]   cmp_low;
  logic [9:0]    cmp_high;
  logic [31:0]   mask_low;
  logic [9:0]    mask_high;
  logic [31:0]   tick_period;
  logic          tick_flag;
  logic          match_flag;

  logic [8:0]    ext;
  logic [32:0]   base;
  logic [31:0]   tick_cnt;
  logic          load_pend;
  logic          time_in_rise;
  logic          step;
  logic          cmp_eval;
  logic          match_now;
  logic          tick_set;
  logic          match_set;
  logic          ext_wrap;

  // apb slave: zero wait states, read data captured in the setup cycle
  assign setup  = i_apb.psel & ~i_apb.penable;
  assign access = i_apb.psel & i_apb.penable;
  assign sel    = ttcc_decode(i_apb.paddr);
  assign wr     = access & i_apb.pwrite;
  assign wdata  = i_apb.pwdata;

  always_comb begin
    read_val = RST_ZERO;
    unique case (sel)
      REG_CTRL: begin
        read_val[CTRL_COUNT_EN_BIT] = count_en;
        read_val[CTRL_TICK_EN_BIT]  = tick_en;
        read_val[CTRL_CMP_EN_BIT]   = cmp_en;
        read_val[CTRL_INC_SEL_BIT]  = inc_sel;
        read_val[CTRL_FILTER_BIT]   = filter;
      end
      REG_INIT_LOW:    read_val = init_low;
      REG_INIT_HIGH:   read_val = {22'h000000, init_high};
      REG_TIME_LOW:    read_val = base[31:0];
      REG_TIME_HIGH:   read_val = {22'h000000, ext, base[32]};
      REG_CMP_LOW:     read_val = cmp_low;
      REG_CMP_HIGH:    read_val = {22'h000000, cmp_high};
      REG_MASK_LOW:    read_val = mask_low;
      REG_MASK_HIGH:   read_val = {22'h000000, mask_high};
      REG_TICK_PERIOD: read_val = tick_period;
      REG_STATUS: begin
        read_val[STAT_TICK_BIT]  = tick_flag;
        read_val[STAT_MATCH_BIT] = match_flag;
      end
      REG_NONE:        read_val = RST_ZERO;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prdata  <= RST_ZERO;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= read_val;
      pslverr <= (sel == REG_NONE);
    end
  end

  assign o_apb.pready  = 1'b1;
  assign o_apb.pslverr = pslverr;
  assign o_apb.prdata  = prdata;

  // control register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_en <= 1'b0;
      tick_en  <= 1'b0;
      cmp_en   <= 1'b0;
      inc_sel  <= 1'b0;
      filter   <= 1'b0;
    end else if (wr && sel == REG_CTRL) begin
      count_en <= wdata[CTRL_COUNT_EN_BIT];
      tick_en  <= wdata[CTRL_TICK_EN_BIT];
      cmp_en   <= wdata[CTRL_CMP_EN_BIT];
      filter   <= wdata[CTRL_FILTER_BIT];
      // mode switch while running would tear the counter
      if (!count_en) begin
        inc_sel <= wdata[CTRL_INC_SEL_BIT];
      end
    end
  end

  // init, compare, mask and tick period registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      init_low    <= RST_ZERO;
      init_high   <= 10'h000;
      cmp_low     <= RST_ZERO;
      cmp_high    <= 10'h000;
      mask_low    <= RST_ZERO;
      mask_high   <= 10'h000;
      tick_period <= TICK_PERIOD_DEFAULT;
    end else if (wr) begin
      unique case (sel)
        REG_INIT_LOW:    init_low    <= wdata;
        REG_INIT_HIGH:   init_high   <= wdata[9:0];
        REG_CMP_LOW:     cmp_low     <= wdata;
        REG_CMP_HIGH:    cmp_high    <= wdata[9:0];
        REG_MASK_LOW:    mask_low    <= wdata;
        REG_MASK_HIGH:   mask_high   <= wdata[9:0];
        REG_TICK_PERIOD: tick_period <= wdata;
        default:         init_low    <= init_low;
      endcase
    end
  end

  // counter reload happens the cycle after the write, once both halves are stored
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      load_pend <= 1'b0;
    end else begin
      load_pend <= wr & (sel == REG_INIT_LOW || sel == REG_INIT_HIGH);
    end
  end

  // edge detect on the synchronised input; inputs above half i_clk are lost
  ttcc_sync_edge u_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async (i_system_time_input_clock),
    .o_rise  (time_in_rise)
  );

  assign step     = time_in_rise & count_en;
  assign ext_wrap = (ext >= EXT_LAST);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ext  <= 9'h000;
      base <= 33'h0_0000_0000;
    end else if (load_pend) begin
      ext  <= init_high[HIGH_EXT_MSB:HIGH_EXT_LSB];
      base <= {init_high[HIGH_TOP_BIT], init_low};
    end else if (step) begin
      ext <= ext_wrap ? 9'h000 : ext + 9'h001;
      if (inc_sel || ext_wrap) begin
        base <= base + 33'h0_0000_0001;
      end
    end
  end

  assign tick_set = step & ~load_pend & tick_en & (tick_cnt >= tick_period - 32'h0000_0001);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_cnt <= RST_ZERO;
    end else if (step) begin
      tick_cnt <= (tick_cnt >= tick_period - 32'h0000_0001) ? RST_ZERO : tick_cnt + 32'h0000_0001;
    end
  end

  // compare only right after a count step so a halted match fires once
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmp_eval <= 1'b0;
    end else begin
      cmp_eval <= step & ~load_pend;
    end
  end

  assign match_now = ((({base[32], ext, base[31:0]} ^ {cmp_high[HIGH_TOP_BIT], cmp_high[HIGH_EXT_MSB:HIGH_EXT_LSB],
                     cmp_low}) & ~{mask_high[HIGH_TOP_BIT], mask_high[HIGH_EXT_MSB:HIGH_EXT_LSB], mask_low})
                     == 42'h000_0000_0000);
  assign match_set = cmp_eval & cmp_en & match_now;

  // sticky status: hardware set beats a same-cycle write-one clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_flag  <= 1'b0;
      match_flag <= 1'b0;
    end else begin
      tick_flag  <= tick_set | (tick_flag & ~(wr && sel == REG_STATUS && wdata[STAT_TICK_BIT]));
      match_flag <= match_set | (match_flag & ~(wr && sel == REG_STATUS && wdata[STAT_MATCH_BIT]));
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tick_event       <= 1'b0;
      o_time_match_event <= 1'b0;
    end else begin
      o_tick_event       <= tick_set;
      o_time_match_event <= match_set;
    end
  end

  ttcc_pkt_filter u_filter (
    .i_clk        (i_clk),
    .i_rst_n      (i_rst_n),
    .i_pkt        (i_pkt),
    .i_filter     (filter),
    .i_stamp_time (base[30:0]),
    .o_pkt_ready  (o_pkt_ready),
    .o_fifo_wr    (o_fifo_wr),
    .o_fifo_data  (o_fifo_data)
  );

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_enable_bits_any: assert property ((wr && sel == REG_CTRL) |=>
      (tick_en == $past(wdata[CTRL_TICK_EN_BIT]) && cmp_en == $past(wdata[CTRL_CMP_EN_BIT])
       && filter == $past(wdata[CTRL_FILTER_BIT])))
    else $error("enable bits not written");
  a_mode_locked: assert property ((wr && sel == REG_CTRL && count_en) |=> $stable(inc_sel))
    else $error("increment select changed while counting");
  a_mode_open: assert property ((wr && sel == REG_CTRL && !count_en) |=>
      inc_sel == $past(wdata[CTRL_INC_SEL_BIT]))
    else $error("increment select not written while halted");
  a_halt_still: assert property ((!count_en && !load_pend) |=> ($stable(ext) && $stable(base)
      && $stable(tick_cnt)))
    else $error("counter moved while halted");
  a_ext_steps: assert property ((step && !load_pend && ext < EXT_LAST) |=>
      ext == $past(ext) + 9'h001)
    else $error("extension did not step");
  a_wrap_base: assert property ((step && !load_pend && !inc_sel && ext == EXT_LAST) |=>
      (ext == 9'h000 && base == $past(base) + 33'h0_0000_0001))
    else $error("wrap did not advance reference");
  a_hold_base: assert property ((step && !load_pend && !inc_sel && ext < EXT_LAST) |=> $stable(base))
    else $error("reference advanced without wrap");
  a_direct_base: assert property ((step && !load_pend && inc_sel) |=>
      base == $past(base) + 33'h0_0000_0001)
    else $error("reference did not step directly");
  a_init_load: assert property ((wr && sel == REG_INIT_LOW) |=> ##1
      (base[31:0] == $past(wdata, 2) && ext == init_high[HIGH_EXT_MSB:HIGH_EXT_LSB]))
    else $error("init write did not load counter");
  a_load_wins: assert property ((load_pend && step) |=>
      base == {$past(init_high[HIGH_TOP_BIT]), $past(init_low)})
    else $error("increment beat init load");
  a_tick_gate: assert property (o_tick_event |-> $past(tick_en))
    else $error("tick event while disabled");
  a_match_gate: assert property (o_time_match_event |-> ($past(cmp_en) && $past(match_now)))
    else $error("match event without enabled match");
  a_match_flag: assert property (match_set |=> match_flag ##1
      (match_flag || $past(wr && sel == REG_STATUS && wdata[STAT_MATCH_BIT])))
    else $error("match flag not sticky");
  a_ctrl_reserved: assert property ((setup && sel == REG_CTRL) |=>
      (prdata[31:6] == 26'h000_0000 && prdata[0] == 1'b0))
    else $error("control reserved bits read nonzero");
  a_high_reserved: assert property ((setup && sel == REG_INIT_HIGH) |=> prdata[31:10] == 22'h00_0000)
    else $error("init high reserved bits read nonzero");
  a_sync_only: assert property (step |-> (count_en && $past(i_system_time_input_clock, 2)))
    else $error("step without synchronised edge");

  // register side and counter corner checks
  a_low_store: assert property ((wr && sel == REG_INIT_LOW) |=> init_low == $past(wdata))
    else $error("init low write not stored");
  a_high_load: assert property ((wr && sel == REG_INIT_HIGH) |=> ##1
      (ext == $past(wdata[HIGH_EXT_MSB:HIGH_EXT_LSB], 2) && base[32] == $past(wdata[HIGH_TOP_BIT], 2)
       && base[31:0] == init_low))
    else $error("init high write did not load counter");
  a_count_write: assert property ((wr && sel == REG_CTRL) |=>
      count_en == $past(wdata[CTRL_COUNT_EN_BIT]))
    else $error("count enable not written");
  a_halt_no_tick: assert property (!count_en |=> !o_tick_event)
    else $error("tick event while halted");
  a_cmp_off_quiet: assert property (!cmp_en |=> !o_time_match_event)
    else $error("match event while compare disabled");
  a_tick_sets_flag: assert property (tick_set |=> (tick_flag && o_tick_event))
    else $error("tick flag not set on tick count");
  a_tick_reach: assert property ((step && tick_en && !load_pend &&
      tick_cnt == tick_period - 32'h0000_0001) |-> tick_set)
    else $error("tick count reached without tick");
  a_tick_restart: assert property ((step && tick_cnt >= tick_period - 32'h0000_0001) |=>
      tick_cnt == RST_ZERO)
    else $error("tick counter did not restart");
  a_ext_wrap_any: assert property ((step && !load_pend && ext > EXT_LAST) |=>
      ext == 9'h000)
    else $error("out of range extension did not wrap");
  a_no_match_load: assert property (load_pend |=> !cmp_eval)
    else $error("compare evaluated on a load");
  a_flag_clear: assert property ((wr && sel == REG_STATUS && wdata[STAT_TICK_BIT] && !tick_set)
      |=> !tick_flag)
    else $error("tick flag not cleared");
  a_unmapped_err: assert property ((setup && sel == REG_NONE) |=> (pslverr && prdata == RST_ZERO))
    else $error("unmapped access not refused");

  c_wrap: cover property (step && !inc_sel && ext == EXT_LAST);
  c_tick: cover property (o_tick_event);
  c_match: cover property (o_time_match_event);
  c_stamp: cover property (o_fifo_wr && o_fifo_data[31]);
  c_load_clash: cover property (load_pend && step);
endmodule // ttcc_top

// >>> test/testbench.sv
`timescale 1ns/1ps
module testbench;
  import ttcc_pkg::*;

  localparam logic [31:0] TICK_P = 32'h0000_0004;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] exp;
    logic        err;
  } ttcc_row_t;

  logic          i_clk;
  logic          i_rst_n;
  ttcc_apb_req_t req;
  ttcc_apb_rsp_t rsp;
  logic          time_in;
  ttcc_pkt_t     pkt;
  logic          pkt_ready;
  logic          fifo_wr;
  logic [31:0]   fifo_data;
  logic          tick_ev;
  logic          match_ev;
  logic [31:0]   rdata;
  logic          rerr;
  int            err_total;
  int            comparisons;
  int            tick_total;
  int            match_total;
  logic [31:0]   fifo_q[$];
  ttcc_row_t     rows[6];

  ttcc_top #(.TICK_PERIOD_DEFAULT(TICK_P)) ttcc_top_inst (
    .i_clk                     (i_clk),
    .i_rst_n                   (i_rst_n),
    .i_apb                     (req),
    .o_apb                     (rsp),
    .i_system_time_input_clock (time_in),
    .i_pkt                     (pkt),
    .o_pkt_ready               (pkt_ready),
    .o_fifo_wr                 (fifo_wr),
    .o_fifo_data               (fifo_data),
    .o_tick_event              (tick_ev),
    .o_time_match_event        (match_ev)
  );

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    if (tick_ev === 1'b1) tick_total++;
    if (match_ev === 1'b1) match_total++;
    if (fifo_wr === 1'b1) fifo_q.push_back(fifo_data);
  end

  task automatic conclude();
    if (err_total == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request held until the edge that samples pready high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge i_clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    rdata = rsp.prdata;
    rerr  = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    if (n >= 50) begin
      err_total++;
      conclude();
    end
  endtask

  // slow time input, well below the sync limit; idle low between steps
  task automatic steps(input int n);
    repeat (n) begin
      @(posedge i_clk) time_in <= 1'b1;
      repeat (3) @(posedge i_clk);
      time_in <= 1'b0;
      repeat (3) @(posedge i_clk);
    end
    repeat (8) @(posedge i_clk);
  endtask

  // called just after an edge; returns just after the taking edge
  task automatic send_word(input logic [31:0] d, input logic l, input logic e);
    int n;
    pkt <= '{valid: 1'b1, last: l, err: e, data: d};
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (pkt_ready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      conclude();
    end
  endtask

  task automatic send_pkt(input logic [31:0] d0, input logic e0, input logic e1, input int exp_n, input logic mark);
    fifo_q.delete();
    @(posedge i_clk);
    send_word(d0, 1'b0, e0);
    send_word(~d0, 1'b1, e1);
    pkt.valid <= 1'b0;
    @(negedge i_clk);
    chk({31'h0, pkt_ready}, {31'h0, exp_n == 0});
    repeat (6) @(posedge i_clk);
    chk(32'(fifo_q.size()), 32'(exp_n));
    if (exp_n == 3) begin
      chk(fifo_q[0], d0);
      chk(fifo_q[1], ~d0);
      chk({31'h0, fifo_q[2][31]}, {31'h0, mark});
      // counter stays halted at 0x13 for every packet case
      chk({1'b0, fifo_q[2][30:0]}, 32'h0000_0013);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask

  task automatic do_reset();
    i_rst_n <= 1'b0;
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
  endtask

  initial begin
    i_rst_n     = 1'b0;
    req         = '0;
    pkt         = '0;
    time_in     = 1'b0;
    err_total   = 0;
    comparisons = 0;
    tick_total  = 0;
    match_total = 0;
    rows[0] = '{OFF_CTRL, 32'hffff_ffff, 32'h0000_003e, 1'b0};
    rows[1] = '{OFF_CTRL, 32'h0000_0000, 32'h0000_0004, 1'b0};
    rows[2] = '{OFF_INIT_LOW, 32'ha5a5_5a5a, 32'ha5a5_5a5a, 1'b0};
    rows[3] = '{OFF_INIT_HIGH, 32'hffff_ffff, 32'h0000_03ff, 1'b0};
    rows[4] = '{8'h2c, 32'h1234_5678, 32'h0000_0000, 1'b1};
    rows[5] = '{OFF_TIME_LOW, 32'hffff_ffff, 32'ha5a5_5a5a, 1'b0};
    do_reset();
    foreach (rows[i]) begin
      apb(1'b1, rows[i].addr, rows[i].wdata);
      apb(1'b0, rows[i].addr, 32'h0);
      chk(rdata, rows[i].exp);
      chk({31'h0, rerr}, {31'h0, rows[i].err});
    end
    // second reset in mid-run, then reset values
    do_reset();
    rd_chk(OFF_CTRL, 32'h0);
    rd_chk(OFF_INIT_LOW, 32'h0);
    rd_chk(OFF_INIT_HIGH, 32'h0);
    rd_chk(OFF_TICK_PERIOD, TICK_P);
    // tick events every four steps, none once disabled
    apb(1'b1, OFF_CTRL, 32'h0000_0030);
    steps(8);
    chk(32'(tick_total), 32'h2);
    apb(1'b1, OFF_CTRL, 32'h0000_0020);
    steps(8);
    chk(32'(tick_total), 32'h2);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rdata & 32'h1, 32'h1);
    // load near the extension wrap, then count in 90 kHz mode
    apb(1'b1, OFF_CTRL, 32'h0);
    apb(1'b1, OFF_INIT_LOW, 32'h0000_0005);
    apb(1'b1, OFF_INIT_HIGH, 32'h0000_0254);
    rd_chk(OFF_TIME_LOW, 32'h0000_0005);
    rd_chk(OFF_TIME_HIGH, 32'h0000_0254);
    apb(1'b1, OFF_CTRL, 32'h0000_0020);
    steps(2);
    rd_chk(OFF_TIME_LOW, 32'h0000_0006);
    rd_chk(OFF_TIME_HIGH, 32'h0000_0000);
    apb(1'b1, OFF_CTRL, 32'h0);
    steps(3);
    rd_chk(OFF_TIME_LOW, 32'h0000_0006);
    rd_chk(OFF_TIME_HIGH, 32'h0000_0000);
    // select accepted while halted, ignored while running
    apb(1'b1, OFF_CTRL, 32'h0000_0004);
    apb(1'b1, OFF_CTRL, 32'h0000_0024);
    apb(1'b1, OFF_CTRL, 32'h0000_0020);
    rd_chk(OFF_CTRL, 32'h0000_0024);
    steps(3);
    rd_chk(OFF_TIME_LOW, 32'h0000_0009);
    rd_chk(OFF_TIME_HIGH, 32'h0000_0006);
    // init write lands on a count step: load wins, the step is lost
    fork
      apb(1'b1, OFF_INIT_LOW, 32'h0000_0040);
      steps(1);
    join
    rd_chk(OFF_TIME_LOW, 32'h0000_0040);
    rd_chk(OFF_TIME_HIGH, 32'h0000_0254);
    // compare with extension masked off; enable cleared before reload
    apb(1'b1, OFF_CTRL, 32'h0000_0004);
    apb(1'b1, OFF_INIT_LOW, 32'h0000_0010);
    apb(1'b1, OFF_INIT_HIGH, 32'h0);
    apb(1'b1, OFF_CMP_LOW, 32'h0000_0012);
    apb(1'b1, OFF_CMP_HIGH, 32'h0);
    apb(1'b1, OFF_MASK_LOW, 32'h0);
    apb(1'b1, OFF_MASK_HIGH, 32'h0000_03ff);
    apb(1'b1, OFF_CTRL, 32'h0000_002c);
    steps(3);
    chk(32'(match_total), 32'h1);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rdata & 32'h2, 32'h2);
    apb(1'b1, OFF_STATUS, 32'h0000_0003);
    rd_chk(OFF_STATUS, 32'h0);
    // packets: marker kept, errored dropped, clean kept under the filter
    apb(1'b1, OFF_CTRL, 32'h0);
    send_pkt(32'h1111_2222, 1'b0, 1'b1, 3, 1'b1);
    apb(1'b1, OFF_CTRL, 32'h0000_0002);
    send_pkt(32'h3333_4444, 1'b1, 1'b0, 0, 1'b0);
    send_pkt(32'h5555_6666, 1'b0, 1'b0, 3, 1'b0);
    conclude();
  end
endmodule // testbench
